/* hdl/strap_cfg_pkg.sv */
// Package for the reset strap configuration block: map, fields, timing
package strap_cfg_pkg;

    // Register byte offsets
    localparam logic [7:0] off_strap_status = 8'h00;
    localparam logic [7:0] off_pin_enable   = 8'h04;
    localparam logic [7:0] off_wait_state   = 8'h08;
    localparam logic [7:0] off_function_sel = 8'h0c;

    // Strap and boot values
    localparam logic [2:0]  boot_from_flash  = 3'h1;
    localparam logic [31:0] rom_start_addr   = 32'h0000_8000;
    localparam logic [31:0] flash_start_addr = 32'h0200_0000;

    // Slowest wait-state timing at reset
    localparam logic [4:0] setup_reset  = 5'h10;
    localparam logic [6:0] strobe_reset = 7'h40;
    localparam logic [3:0] hold_reset   = 4'h8;
    localparam logic [7:0] access_total = 8'h58;

    // Pin-enable field layout
    localparam int ena_ba1_pos  = 0;
    localparam int ena_a1_pos   = 1;
    localparam int ena_a0_pos   = 3;
    localparam int ena_a14_pos  = 17;
    localparam int ena_ba0_pos  = 18;
    localparam int ena_dhi_pos  = 19;
    localparam int ena_ahi_pos  = 20;
    localparam int ena_sel2_pos = 27;

    // Function-select layout
    localparam int sel2_pos = 0;
    localparam int sel4_pos = 1;

    // Captured straps
    typedef struct packed {
        logic [2:0] boot_select;
        logic [2:0] async_if_config;
        logic       osc_range_select;
    } strap_type;

    // Pin routing result
    typedef struct packed {
        logic        ba1;
        logic        ba0;
        logic        a14;
        logic [13:0] a_low;
        logic [6:0]  a_high;
        logic        d_high;
    } pin_route_type;

endpackage

/* hdl/boot_strap_pin_config.sv */
// Reset strap capture, boot address, address pin mux and wait-state reset
// Operation
// [RL1] Start at ROM 0x8000 unless boot select is 001, then external flash.
// [RL2] Sample the 3-bit interface strap at reset to pick driven address pins.
// [RL3] Pins not enabled as address or data fall back to general-purpose I/O.
// [RL4] Enabled address pins are contiguous upward from byte address bit 1.
// [RL5] Up to 23 address lines, 2 chip selects, 8 or 16-bit data only.
// [RL6] 16-bit: byte bit 1 is half-word address, byte bit 0 carries A14.
// [RL7] 8-bit: both byte pins are low address bits; more via function select 2.
// [RL8] Address pins 15 to 21 leave reset as I/O until select 4 is set; code gates only six upper slots, so pin 21 stays I/O.
// [RL9] Codes 0/4 expose A1-A2; 1/5 add A14, A0-A13; 2/6 use BA0; 4-6 add D8-15.
// [RL10] Strap only gates controller address bits onto pins, never its behaviour.
// [RL11] Wait states reset to 16 setup, 64 strobe, 8 hold: 88 cycles.
// [RL12] Latch oscillator range at reset: 0 is 15-35 MHz, 1 is 30-40 MHz.
// [RL13] Board sets oscillator range once before start and never toggles it.
// [RL14] Board chooses straps so address outputs never fight driven inputs.
// [RL15] ROM boot with NAND may reuse freed I/O pins as ALE and CLE.
// [RL16] Straps captured at reset release and held until the next reset.
`timescale 1ns/100ps

module boot_strap_pin_config
    import strap_cfg_pkg::*;
#(
    parameter int addr_width = 23
)
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic [2:0]            boot_select,
    input  wire logic [2:0]            async_if_config,
    input  wire logic                  osc_range_select,
    input  wire logic [addr_width-1:0] ctrl_address,
    input  wire logic                  ctrl_data_wide,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                boot_address,
    output logic                       osc_high_range,
    output logic                       data_high_enable,
    output logic [addr_width-1:0]      pin_address,
    output logic [addr_width-1:0]      pin_address_oe_n,
    output logic [4:0]                 setup_cycles,
    output logic [6:0]                 strobe_cycles,
    output logic [3:0]                 hold_cycles
);
    import strap_cfg_pkg::*;

    // Pin slot indices inside the pin_address vector
    localparam int slot_ba1 = 0;
    localparam int slot_ba0 = 1;
    localparam int slot_a0  = 2;
    localparam int slot_a14 = 16;
    localparam int slot_ahi = 17;

    logic [2:0]    sync_a_boot;
    logic [2:0]    sync_b_boot;
    logic [2:0]    sync_a_cfg;
    logic [2:0]    sync_b_cfg;
    logic          sync_a_osc;
    logic          sync_b_osc;
    logic          captured;
    strap_type     strap;
    pin_route_type next_route;
    pin_route_type route;
    logic          sel2;
    logic          sel4;
    logic          wr_pend;
    logic          rd_pend;
    logic [7:0]    addr_q;
    logic [31:0]   next_rdata;

    // Two-stage synchronisers on strap pins; first stage read only by second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_a_boot <= 3'h0;
            sync_b_boot <= 3'h0;
            sync_a_cfg  <= 3'h0;
            sync_b_cfg  <= 3'h0;
            sync_a_osc  <= 1'b0;
            sync_b_osc  <= 1'b0;
        end
        else
        begin
            sync_a_boot <= boot_select;
            sync_b_boot <= sync_a_boot;
            sync_a_cfg  <= async_if_config;
            sync_b_cfg  <= sync_a_cfg;
            sync_a_osc  <= osc_range_select;
            sync_b_osc  <= sync_a_osc;
        end
    end

    // Capture once, on the third edge after release, so synchronisers hold pin values.
    // Later pin activity is ignored until the next reset.
    logic [1:0] settle;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            settle   <= 2'h0;
            captured <= 1'b0;
            strap    <= '0;
        end
        else if (!captured)
        begin
            settle <= settle + 2'h1;
            if (settle == 2'h2)
            begin
                captured <= 1'b1;                          // see [RL16]
                strap    <= '{sync_b_boot, sync_b_cfg, sync_b_osc}; // see [RL2]
            end
        end
    end

    // Strap decode to pin routing; codes 3 and 7 treated as code 0 (safest)
    always_comb
    begin
        next_route        = '0;
        next_route.a_low  = 14'h0006;                      // see [RL9]
        unique case (strap.async_if_config[1:0])
            2'h1:
            begin
                // In 8-bit width A14 waits for select 4 instead
                next_route.a14   = ctrl_data_wide;         // see [RL6]
                next_route.ba1   = 1'b1;                   // see [RL4]
                next_route.a_low = 14'h3fff;
            end
            2'h2:
            begin
                next_route.ba0   = 1'b1;                   // see [RL7]
                next_route.ba1   = 1'b1;
                next_route.a_low = 14'h3fff;
            end
            default:
            begin
                next_route.a_low = 14'h0006;
            end
        endcase
        // Code 7 behaves as code 0, so its upper data lane stays I/O
        next_route.d_high = strap.async_if_config[2]
                            && (strap.async_if_config[1:0] != 2'h3); // see [RL9]
        // Upper pins and extra byte lane only after software select
        next_route.a_high = sel4 ? 7'h7f : 7'h00;          // see [RL8]
        if (sel2 && !ctrl_data_wide && strap.async_if_config[1:0] == 2'h1)
            next_route.ba0 = 1'b1;                         // see [RL7]
        if (sel4 && !ctrl_data_wide)
            next_route.a14 = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            route <= '0;
        else
            route <= captured ? next_route : '0;
    end

    // Pin drive: controller address passes unchanged, strap only gates it.
    // Disabled pins are released to general-purpose I/O (oe_n high).
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_address      <= '0;
            pin_address_oe_n <= '1;
            data_high_enable <= 1'b0;
        end
        else
        begin
            pin_address      <= ctrl_address;              // see [RL10]
            pin_address_oe_n[slot_ba1] <= !route.ba1;      // see [RL3]
            pin_address_oe_n[slot_ba0] <= !(route.ba0 || (route.a14 && ctrl_data_wide));
            pin_address_oe_n[slot_a0 +: 14] <= ~route.a_low;
            pin_address_oe_n[slot_a14] <= !(route.a14 && !ctrl_data_wide);
            pin_address_oe_n[slot_ahi +: 6] <= ~route.a_high[5:0];
            data_high_enable <= route.d_high;              // see [RL5]
        end
    end

    // Boot address and oscillator range follow captured straps
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            boot_address   <= rom_start_addr;
            osc_high_range <= 1'b0;
        end
        else
        begin
            boot_address   <= (strap.boot_select == boot_from_flash)
                              ? flash_start_addr : rom_start_addr; // see [RL1]
            osc_high_range <= strap.osc_range_select;      // see [RL12]
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            addr_q  <= haddr[7:0];
        end
    end

    // Writable timing and function-select registers, reset to slowest timing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            setup_cycles  <= setup_reset;                  // see [RL11]
            strobe_cycles <= strobe_reset;
            hold_cycles   <= hold_reset;
            sel2          <= 1'b0;
            sel4          <= 1'b0;
        end
        else if (wr_pend && addr_q == off_wait_state)
        begin
            setup_cycles  <= hwdata[4:0];
            strobe_cycles <= hwdata[14:8];
            hold_cycles   <= hwdata[19:16];
        end
        else if (wr_pend && addr_q == off_function_sel)
        begin
            sel2 <= hwdata[sel2_pos];
            sel4 <= hwdata[sel4_pos];
        end
    end

    // Read mux, registered from the address phase
    always_comb
    begin
        next_rdata = 32'h0;
        unique case (haddr[7:0])
            off_strap_status:
                next_rdata = {24'h0, captured, strap};
            off_pin_enable:
            begin
                // Fields placed by the package layout so software sees one map
                next_rdata[ena_ba1_pos]      = route.ba1;
                next_rdata[ena_a0_pos +: 14] = route.a_low;
                next_rdata[ena_a14_pos]      = route.a14;
                next_rdata[ena_ba0_pos]      = route.ba0;
                next_rdata[ena_dhi_pos]      = route.d_high;
                next_rdata[ena_ahi_pos +: 7] = route.a_high;
                next_rdata[ena_sel2_pos]     = sel2;
            end
            off_wait_state:
                next_rdata = {12'h0, hold_cycles, 1'b0, strobe_cycles, 3'h0, setup_cycles};
            off_function_sel:
                next_rdata = {30'h0, sel4, sel2};
            default:
                next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            if (hready && hsel && htrans[1] && !hwrite)
                hrdata <= next_rdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Checks
    sequence s_captured;
        $rose(captured);
    endsequence

    property p_boot_addr;
        @(posedge hclk) disable iff (!hresetn)
        s_captured |=> ##1 boot_address == ((strap.boot_select == boot_from_flash)
            ? flash_start_addr : rom_start_addr);
    endproperty
    a_boot_addr: assert property (p_boot_addr) else $error("boot address wrong"); // see [RL1]

    property p_hold_strap;
        @(posedge hclk) disable iff (!hresetn)
        captured |=> $stable(strap);
    endproperty
    a_hold_strap: assert property (p_hold_strap) else $error("strap changed"); // see [RL16]

    property p_capture_time;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> ##3 captured;
    endproperty
    a_capture_time: assert property (p_capture_time) else $error("late capture"); // see [RL2]

    property p_a1a2;
        @(posedge hclk) disable iff (!hresetn)
        captured ##2 1'b1 |-> pin_address_oe_n[slot_a0+2:slot_a0+1] == 2'b00;
    endproperty
    a_a1a2: assert property (p_a1a2) else $error("A1 A2 not driven"); // see [RL9]

    property p_code0_gpio;
        @(posedge hclk) disable iff (!hresetn)
        (captured && strap.async_if_config[1:0] == 2'h0) ##2 1'b1
            |-> pin_address_oe_n[slot_ba1] && pin_address_oe_n[slot_a0];
    endproperty
    a_code0_gpio: assert property (p_code0_gpio) else $error("pin not released"); // see [RL3]

    property p_upper_gpio;
        @(posedge hclk) disable iff (!hresetn)
        !sel4 ##2 !sel4 |-> &pin_address_oe_n[slot_ahi +: 6];
    endproperty
    a_upper_gpio: assert property (p_upper_gpio) else $error("upper pin driven"); // see [RL8]

    property p_pass;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> pin_address == $past(ctrl_address);
    endproperty
    a_pass: assert property (p_pass) else $error("address altered"); // see [RL10]

    property p_osc;
        @(posedge hclk) disable iff (!hresetn)
        captured |=> osc_high_range == $past(strap.osc_range_select);
    endproperty
    a_osc: assert property (p_osc) else $error("osc range wrong"); // see [RL12]

    property p_dhigh;
        @(posedge hclk) disable iff (!hresetn)
        captured ##2 1'b1 |-> data_high_enable == (strap.async_if_config[2]
            && strap.async_if_config[1:0] != 2'h3);
    endproperty
    a_dhigh: assert property (p_dhigh) else $error("data high wrong"); // see [RL9]

    property p_timing_total;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> 8'(setup_cycles + strobe_cycles + hold_cycles) == access_total;
    endproperty
    a_timing_total: assert property (p_timing_total) else $error("not slowest"); // see [RL11]

endmodule

/* verif/board_straps.sv */
// Board strap model: resistor levels at reset, reused pins after boot
`timescale 1ns/100ps

module board_straps
(
    input  wire logic       reuse,
    input  wire logic [2:0] boot_level,
    input  wire logic [2:0] cfg_level,
    input  wire logic       osc_level,
    output logic [2:0]      boot_select,
    output logic [2:0]      async_if_config,
    output logic            osc_range_select
);
    // After boot, freed pins carry NAND control, so levels flip to expose stale capture
    assign boot_select      = reuse ? ~boot_level : boot_level;
    assign async_if_config  = reuse ? ~cfg_level : cfg_level;
    // Range chosen once per reset, never toggled while running
    assign osc_range_select = osc_level;
endmodule

/* verif/boot_strap_pin_config_tb.sv */
// Self-checking bench for strap capture, pin routing and wait-state registers
`timescale 1ns/100ps

module boot_strap_pin_config_tb;
    import strap_cfg_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        reuse;
    logic [2:0]  boot_level;
    logic [2:0]  cfg_level;
    logic        osc_level;
    logic [22:0] ctrl_address = 23'h2a5a5a;
    logic        ctrl_data_wide;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    wire logic [2:0]  boot_select;
    wire logic [2:0]  async_if_config;
    wire logic        osc_range_select;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] boot_address;
    logic        osc_high_range;
    logic        data_high_enable;
    logic [22:0] pin_address;
    logic [22:0] pin_address_oe_n;
    logic [4:0]  setup_cycles;
    logic [6:0]  strobe_cycles;
    logic [3:0]  hold_cycles;
    int          mismatches;
    int          comparisons;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    board_straps u_board_straps (.reuse(reuse), .boot_level(boot_level),
        .cfg_level(cfg_level), .osc_level(osc_level), .boot_select(boot_select),
        .async_if_config(async_if_config), .osc_range_select(osc_range_select));

    boot_strap_pin_config u_boot_strap_pin_config (.hclk(hclk), .hresetn(hresetn),
        .boot_select(boot_select), .async_if_config(async_if_config),
        .osc_range_select(osc_range_select), .ctrl_address(ctrl_address),
        .ctrl_data_wide(ctrl_data_wide), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .boot_address(boot_address), .osc_high_range(osc_high_range),
        .data_high_enable(data_high_enable), .pin_address(pin_address),
        .pin_address_oe_n(pin_address_oe_n), .setup_cycles(setup_cycles),
        .strobe_cycles(strobe_cycles), .hold_cycles(hold_cycles));

    // 40 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Controller address keeps moving so the pin path sees traffic
    always @(posedge hclk)
        ctrl_address <= ctrl_address + 23'h000001;

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hang
    task automatic wait_ready;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask

    // Address phase held until ready, then data phase until ready again
    task automatic ahb_xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready;
        rdata = hrdata;
        chk_word({31'h0, hresp}, 32'h0, "response");
    endtask

    task automatic do_reset(input logic [2:0] bt, input logic [2:0] cf, input logic os,
                            input logic wide);
        @(posedge hclk);
        hresetn        <= 1'b0;
        reuse          <= 1'b0;
        boot_level     <= bt;
        cfg_level      <= cf;
        osc_level      <= os;
        ctrl_data_wide <= wide;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        #1;
    endtask

    // Every strap code, 16-bit width, then pins change after capture
    task automatic t_codes;
        logic [31:0] rd;
        logic [22:0] drv;
        for (int i = 0; i < 8; i++)
        begin
            do_reset(i[2:0], i[2:0], i[0], 1'b1);
            // 16-bit codes 1, 2, 5 and 6 drive BA1, BA0 and A0-A13; the rest only A1-A2
            drv = (i % 4 == 1 || i % 4 == 2) ? 23'h00ffff : 23'h000018;
            for (int k = 0; k < 2; k++)
            begin
                chk_word({9'h0, ~pin_address_oe_n}, {9'h0, drv},
                         "pins");
                chk_word({31'h0, data_high_enable}, {31'h0, i > 3 && i < 7},
                         "d_high");
                chk_word(boot_address, (i == 1) ? flash_start_addr : rom_start_addr,
                         "boot");
                chk_word({31'h0, osc_high_range}, {31'h0, i[0]}, "osc");
                chk_word({9'h0, pin_address}, {9'h0, ctrl_address - 23'h1},
                         "addr pass");
                chk_word({12'h0, hold_cycles, 1'b0, strobe_cycles, 3'h0, setup_cycles},
                         {12'h0, hold_reset, 1'b0, strobe_reset, 3'h0, setup_reset},
                         "wait");
                chk_word({27'h0, setup_cycles} + {25'h0, strobe_cycles} + {28'h0, hold_cycles},
                         {24'h0, access_total}, "total");
                ahb_xfer({24'h0, off_strap_status}, 1'b0, 32'h0, rd);
                chk_word(rd, {24'h0, 1'b1, i[2:0], i[2:0], i[0]}, "status");
                reuse <= 1'b1;
                repeat (6) @(posedge hclk);
                #1;
            end
        end
        $display("t_codes done");
    endtask

    // Wait-state write, unmapped access, upper address enable
    task automatic t_regs;
        logic [31:0] rd;
        do_reset(3'h0, 3'h1, 1'b0, 1'b1);
        ahb_xfer({24'h0, off_wait_state}, 1'b1, 32'h0003_2105, rd);
        ahb_xfer(32'h0000_0010, 1'b1, 32'hffff_ffff, rd);
        ahb_xfer({24'h0, off_wait_state}, 1'b0, 32'h0, rd);
        chk_word(rd, 32'h0003_2105, "wait rd");
        ahb_xfer(32'h0000_0010, 1'b0, 32'h0, rd);
        chk_word(rd, 32'h0, "unmapped");
        chk_word({12'h0, hold_cycles, 1'b0, strobe_cycles, 3'h0, setup_cycles},
                 32'h0003_2105, "wait out");
        ahb_xfer({24'h0, off_function_sel}, 1'b1, 32'h0000_0002, rd);
        repeat (3) @(posedge hclk);
        #1;
        chk_word({26'h0, ~pin_address_oe_n[22:17]}, 32'h3f, "a_high");
        // Code 1, 16-bit: BA1, A0-A13, A14 and the upper pins after select 4
        ahb_xfer({24'h0, off_pin_enable}, 1'b0, 32'h0, rd);
        chk_word(rd, (32'h1 << ena_ba1_pos) | (32'h3fff << ena_a0_pos)
                     | (32'h1 << ena_a14_pos) | (32'h7f << ena_ahi_pos),
                 "pin view");
        $display("t_regs done");
    endtask

    // 8-bit width: byte pins, then function selects add BA0, A14 and upper bits
    task automatic t_byte;
        logic [31:0] rd;
        do_reset(3'h0, 3'h2, 1'b1, 1'b0);
        chk_word({30'h0, ~pin_address_oe_n[1:0]}, 32'h3, "byte pins");
        do_reset(3'h0, 3'h1, 1'b1, 1'b0);
        chk_word({25'h0, ~pin_address_oe_n[22:16]}, 32'h0, "upper off");
        ahb_xfer({24'h0, off_function_sel}, 1'b1, 32'h0000_0003, rd);
        ahb_xfer({24'h0, off_function_sel}, 1'b0, 32'h0, rd);
        chk_word(rd, 32'h3, "sel rd");
        repeat (3) @(posedge hclk);
        #1;
        chk_word({31'h0, pin_address_oe_n[1]}, 32'h0, "ba0 sel2");
        chk_word({25'h0, ~pin_address_oe_n[22:16]}, 32'h7f, "upper on");
        $display("t_byte done");
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        mismatches     = 0;
        comparisons    = 0;
        hresetn        = 1'b0;
        reuse          = 1'b0;
        boot_level     = 3'h0;
        cfg_level      = 3'h0;
        osc_level      = 1'b0;
        ctrl_data_wide = 1'b1;
        hsel           = 1'b0;
        haddr          = 32'h0;
        htrans         = 2'h0;
        hwrite         = 1'b0;
        hsize          = 3'h2;
        hwdata         = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_codes;
        t_regs;
        t_byte;
        tally_and_finish;
    end

    // Watchdog: the run needs well under a thousand cycles
    initial
    begin
        #(25 * 5000);
        mismatches++;
        tally_and_finish;
    end
endmodule
